// >>> include/runaway_monitor_params.svh
`ifndef RUNAWAY_MONITOR_PARAMS_SVH
`define RUNAWAY_MONITOR_PARAMS_SVH

// Device register map seen over the link.
`define RM_CTL_ADDR          16'h5040
`define RM_ST_ADDR           16'h5041

// Control register fields and reset value.
`define RM_KEY_LSB           0
`define RM_KEY_MSB           3
`define RM_RESTART_BIT       4
`define RM_KEY_STOP          4'hA
`define RM_CTL_RESET         8'h0A

// Status and mode register fields and reset value.
`define RM_FLAG_BIT          0
`define RM_MODE_BIT          1
`define RM_ST_RESET          8'h00

// Tick divider (low-speed oscillator periods per regulated tick) and last count before overflow.
`define RM_DIV_LAST          7'h7F
`define RM_COUNT_LAST        10'h3FF

// Controller register map on the software port.
`define HC_EVT_ADDR          8'h00
`define HC_MASK_ADDR         8'h04
`define HC_FWD_WR_ADDR       8'h08
`define HC_FWD_RD_ADDR       8'h0C
`define HC_READBACK_ADDR     8'h10
`define HC_EVT_NMI_BIT       0
`define HC_EVT_RST_BIT       1
`define HC_SEL_BIT           8
`define HC_EVT_RESET         2'h0
`define HC_MASK_RESET        2'h0

`endif

// >>> include/runaway_monitor_pkg.sv
package runaway_monitor_pkg;

    // Register address and data on the link.
    typedef logic [15:0] reg_addr_t;
    typedef logic [7:0]  reg_byte_t;

    // Action taken when the counter overflows.
    typedef enum logic {
        ACT_NMI   = 1'b0,
        ACT_RESET = 1'b1
    } overflow_action_e;

endpackage

// >>> include/runaway_monitor_if.sv
`timescale 1ns/100ps

interface runaway_monitor_if;
    // Register access from the CPU end, answered one cycle later.
    runaway_monitor_pkg::reg_addr_t addr;
    runaway_monitor_pkg::reg_byte_t wdata;
    logic                           wr;
    logic                           rd;
    runaway_monitor_pkg::reg_byte_t rdata;
    // Overflow requests toward the CPU, one-cycle pulses.
    logic                           nmi_req;
    logic                           rst_req;

    modport dev (
        input  addr,
        input  wdata,
        input  wr,
        input  rd,
        output rdata,
        output nmi_req,
        output rst_req
    );

    modport cpu (
        output addr,
        output wdata,
        output wr,
        output rd,
        input  rdata,
        input  nmi_req,
        input  rst_req
    );
endinterface

// >>> verilog/runaway_monitor_device.sv
// Chosen here: the address-and-strobe port.
`timescale 1ns/100ps
`include "runaway_monitor_params.svh"

module runaway_monitor_device (
    // Clock, reset and enable.
    input  wire logic          i_ref_clk,
    input  wire logic          i_reset_n,
    input  wire logic          i_clk_en,
    // Clock generator and power-mode inputs.
    input  wire logic          i_low_speed_osc,
    input  wire logic          i_sleep_mode,
    input  wire logic          i_rtc_run_start,
    // Register access and requests toward the CPU.
    runaway_monitor_if.dev     link
);

    logic       osc_meta_q;
    logic       osc_sync_q;
    logic       osc_prev_q;
    logic [6:0] div_q;
    logic [9:0] count_q;
    logic [3:0] run_stop_key_q;
    logic       overflow_action_select_q;
    logic       overflow_nmi_flag_q;
    logic       nmi_q;
    logic       rst_q;
    logic [7:0] rdata_q;
    logic       osc_rise;
    logic       tick;
    logic       wr_ctl;
    logic       wr_st;
    logic       restart;
    logic       running;
    logic       overflow;

    // Two-flop synchroniser for the oscillator pin, plus a third flop for edges.
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            osc_meta_q <= 1'b0;
            osc_sync_q <= 1'b0;
            osc_prev_q <= 1'b0;
        end else if (i_clk_en) begin
            osc_meta_q <= i_low_speed_osc;
            osc_sync_q <= osc_meta_q;
            osc_prev_q <= osc_sync_q;
        end
    end

    // Decode of register writes and the derived control terms.
    assign osc_rise = osc_sync_q & ~osc_prev_q;
    assign wr_ctl   = link.wr && (link.addr == `RM_CTL_ADDR);
    assign wr_st    = link.wr && (link.addr == `RM_ST_ADDR);
    assign restart  = wr_ctl && link.wdata[`RM_RESTART_BIT];
    assign running  = (run_stop_key_q != `RM_KEY_STOP);
    // The tick is withheld in sleep; halt does not gate it.
    assign tick     = osc_rise && (div_q == `RM_DIV_LAST)
                      && !i_sleep_mode && !i_rtc_run_start;
    // A restart in the same cycle wins over the overflow.
    assign overflow = running && tick && (count_q == `RM_COUNT_LAST) && !restart;

    // Divider of oscillator periods; an RTC start begins a fresh tick period.
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            div_q <= 7'h00;
        end else if (i_clk_en) begin
            if (i_rtc_run_start) begin
                div_q <= 7'h00;
            end else if (osc_rise) begin
                div_q <= div_q + 7'h01;
            end
        end
    end

    // Run/stop key and mode select, written by software.
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            run_stop_key_q           <= `RM_KEY_STOP;
            overflow_action_select_q <= 1'b0;
        end else if (i_clk_en) begin
            if (wr_ctl) begin
                run_stop_key_q <= link.wdata[`RM_KEY_MSB:`RM_KEY_LSB];
            end
            if (wr_st) begin
                overflow_action_select_q <= link.wdata[`RM_MODE_BIT];
            end
        end
    end

    // Ten-bit up counter; wraps to zero on overflow and keeps running.
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            count_q <= 10'h000;
        end else if (i_clk_en) begin
            if (restart) begin
                count_q <= 10'h000;
            end else if (running && tick) begin
                count_q <= count_q + 10'h001;
            end
        end
    end

    // Overflow flag: set in either mode, cleared by restart; a restart in the same cycle wins.
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            overflow_nmi_flag_q <= 1'b0;
        end else if (i_clk_en) begin
            if (overflow) begin
                overflow_nmi_flag_q <= 1'b1;
            end else if (restart) begin
                overflow_nmi_flag_q <= 1'b0;
            end
        end
    end

    // One-cycle request pulses toward the CPU, steered by the mode bit.
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            nmi_q <= 1'b0;
            rst_q <= 1'b0;
        end else if (i_clk_en) begin
            nmi_q <= overflow && (overflow_action_select_q == runaway_monitor_pkg::ACT_NMI);
            rst_q <= overflow && (overflow_action_select_q == runaway_monitor_pkg::ACT_RESET);
        end
    end

    // Read data stand one cycle after the strobe; reserved bits read zero.
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rdata_q <= 8'h00;
        end else if (i_clk_en) begin
            rdata_q <= 8'h00;
            if (link.rd && (link.addr == `RM_CTL_ADDR)) begin
                rdata_q <= {4'h0, run_stop_key_q};
            end else if (link.rd && (link.addr == `RM_ST_ADDR)) begin
                rdata_q <= {6'h00, overflow_action_select_q, overflow_nmi_flag_q};
            end
        end
    end

    // Link outputs come straight from flops.
    assign link.rdata   = rdata_q;
    assign link.nmi_req = nmi_q;
    assign link.rst_req = rst_q;

endmodule

// >>> verilog/runaway_monitor_cpu_end.sv
`timescale 1ns/100ps
`include "runaway_monitor_params.svh"

module runaway_monitor_cpu_end (
    // Clock, reset and enable.
    input  wire logic          i_ref_clk,
    input  wire logic          i_reset_n,
    input  wire logic          i_clk_en,
    // Software register port.
    input  wire logic [7:0]    i_addr,
    input  wire logic [31:0]   i_wdata,
    input  wire logic          i_wr,
    input  wire logic          i_rd,
    output logic      [31:0]   o_rdata,
    // Interrupt and system reset request.
    output logic               o_irq,
    output logic               o_cpu_reset,
    // Link to the watchdog.
    runaway_monitor_if.cpu     link
);

    logic [1:0]  evt_q;
    logic [1:0]  mask_q;
    logic [15:0] addr_q;
    logic [7:0]  wdata_q;
    logic        wr_q;
    logic        rd_q;
    logic        rd_pend_q;
    logic [7:0]  readback_q;
    logic [31:0] rdata_q;
    logic        irq_q;
    logic        cpu_reset_q;
    logic        fwd_wr;
    logic        fwd_rd;
    logic [1:0]  evt_set;
    logic [1:0]  evt_clr;

    // Decode of software writes.
    assign fwd_wr  = i_wr && (i_addr == `HC_FWD_WR_ADDR);
    assign fwd_rd  = i_wr && (i_addr == `HC_FWD_RD_ADDR);
    assign evt_set = {link.rst_req, link.nmi_req};
    assign evt_clr = (i_wr && (i_addr == `HC_EVT_ADDR)) ? i_wdata[1:0] : 2'h0;

    // Sticky events, cleared by writing one; a new event wins over the clear.
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            evt_q <= `HC_EVT_RESET;
        end else if (i_clk_en) begin
            evt_q <= (evt_q & ~evt_clr) | evt_set;
        end
    end

    // Mask register.
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            mask_q <= `HC_MASK_RESET;
        end else if (i_clk_en && i_wr && (i_addr == `HC_MASK_ADDR)) begin
            mask_q <= i_wdata[1:0];
        end
    end

    // Forwarded accesses: one-cycle strobes on the link; bit 8 picks status register.
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            addr_q  <= `RM_CTL_ADDR;
            wdata_q <= 8'h00;
            wr_q    <= 1'b0;
            rd_q    <= 1'b0;
        end else if (i_clk_en) begin
            wr_q <= fwd_wr;
            rd_q <= fwd_rd;
            if (fwd_wr || fwd_rd) begin
                addr_q <= i_wdata[`HC_SEL_BIT] ? `RM_ST_ADDR : `RM_CTL_ADDR;
            end
            if (fwd_wr) begin
                wdata_q <= i_wdata[7:0];
            end
        end
    end

    // Capture the device answer one cycle after the link read strobe.
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rd_pend_q  <= 1'b0;
            readback_q <= 8'h00;
        end else if (i_clk_en) begin
            rd_pend_q <= rd_q;
            if (rd_pend_q) begin
                readback_q <= link.rdata;
            end
        end
    end

    // Software read data one cycle after the strobe; outputs from flops.
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rdata_q     <= 32'h0000_0000;
            irq_q       <= 1'b0;
            cpu_reset_q <= 1'b0;
        end else if (i_clk_en) begin
            irq_q       <= |(((evt_q & ~evt_clr) | evt_set) & mask_q);
            cpu_reset_q <= link.rst_req;
            rdata_q     <= 32'h0000_0000;
            if (i_rd) begin
                unique case (i_addr)
                    `HC_EVT_ADDR:      rdata_q <= {30'h0, evt_q};
                    `HC_MASK_ADDR:     rdata_q <= {30'h0, mask_q};
                    `HC_READBACK_ADDR: rdata_q <= {24'h0, readback_q};
                    default:           rdata_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign link.addr   = addr_q;
    assign link.wdata  = wdata_q;
    assign link.wr     = wr_q;
    assign link.rd     = rd_q;
    assign o_rdata     = rdata_q;
    assign o_irq       = irq_q;
    assign o_cpu_reset = cpu_reset_q;

endmodule

// >>> testbench/runaway_monitor_checker.sv
`timescale 1ns/100ps
`include "runaway_monitor_params.svh"
module runaway_monitor_checker (
    // Clock and reset.
    input wire logic                           i_ref_clk,
    input wire logic                           i_reset_n,
    // Link signals.
    input wire runaway_monitor_pkg::reg_addr_t addr,
    input wire runaway_monitor_pkg::reg_byte_t wdata,
    input wire logic                           wr,
    input wire logic                           rd,
    input wire runaway_monitor_pkg::reg_byte_t rdata,
    input wire logic                           nmi_req,
    input wire logic                           rst_req
);
    logic [3:0] key_q;
    logic       mode_q;
    logic       flag_q;

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_reset_n);

    // Shadow copies of the key, mode and flag as seen from the link.
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            key_q <= `RM_KEY_STOP;
        end else if (wr && addr == `RM_CTL_ADDR) begin
            key_q <= wdata[3:0];
        end
    end
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            mode_q <= 1'b0;
        end else if (wr && addr == `RM_ST_ADDR) begin
            mode_q <= wdata[`RM_MODE_BIT];
        end
    end
    // A restart write wins over a request seen in the same cycle.
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            flag_q <= 1'b0;
        end else if (wr && addr == `RM_CTL_ADDR && wdata[`RM_RESTART_BIT]) begin
            flag_q <= 1'b0;
        end else if (nmi_req || rst_req) begin
            flag_q <= 1'b1;
        end
    end

    nmi_pulse_a: assert property (nmi_req |=> !nmi_req)
        else $error("NMI request longer than one cycle.");
    reset_pulse_a: assert property (rst_req |=> !rst_req)
        else $error("Reset request longer than one cycle.");
    request_exclusive_a: assert property (!(nmi_req && rst_req))
        else $error("Both requests at once.");
    idle_rdata_a: assert property (!rd |=> rdata == 8'h00)
        else $error("Read data outside a read answer.");
    control_read_a: assert property (rd && addr == `RM_CTL_ADDR |=> rdata == {4'h0, key_q})
        else $error("Control read mismatch.");
    status_read_a: assert property (rd && addr == `RM_ST_ADDR |=> rdata == {6'h00, mode_q, flag_q})
        else $error("Status read mismatch.");
    nmi_mode_a: assert property (nmi_req |-> $past(mode_q) == 1'b0)
        else $error("NMI request in reset mode.");
    reset_mode_a: assert property (rst_req |-> $past(mode_q) == 1'b1)
        else $error("Reset request in NMI mode.");
    stopped_quiet_a: assert property (nmi_req || rst_req |-> $past(key_q) != `RM_KEY_STOP)
        else $error("Request while stopped.");
endmodule

// >>> testbench/tb_top.sv
`timescale 1ns/100ps
module tb_top;
    logic        i_ref_clk = 1'b0;
    logic        i_reset_n = 1'b0;
    logic        osc = 1'b0;
    logic        sleep = 1'b0;
    logic        rtc = 1'b0;
    logic [7:0]  i_addr = 8'h00;
    logic [31:0] i_wdata = 32'h0000_0000;
    logic        i_wr = 1'b0;
    logic        i_rd = 1'b0;
    logic [31:0] o_rdata;
    logic        o_irq;
    logic        o_cpu_reset;
    logic [31:0] rd_q;
    int          failures = 0;
    int          samples_checked = 0;
    int          cyc = 0;
    int          t0 = 0;

    runaway_monitor_if link_if ();
    runaway_monitor_device i_runaway_monitor_device (.i_ref_clk(i_ref_clk),
        .i_reset_n(i_reset_n), .i_clk_en(1'b1), .i_low_speed_osc(osc),
        .i_sleep_mode(sleep), .i_rtc_run_start(rtc), .link(link_if.dev));
    runaway_monitor_cpu_end i_runaway_monitor_cpu_end (.i_ref_clk(i_ref_clk),
        .i_reset_n(i_reset_n), .i_clk_en(1'b1), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq),
        .o_cpu_reset(o_cpu_reset), .link(link_if.cpu));
    runaway_monitor_checker i_runaway_monitor_checker (.i_ref_clk(i_ref_clk),
        .i_reset_n(i_reset_n), .addr(link_if.addr), .wdata(link_if.wdata),
        .wr(link_if.wr), .rd(link_if.rd), .rdata(link_if.rdata),
        .nmi_req(link_if.nmi_req), .rst_req(link_if.rst_req));

    // System clock of 4 ns.
    always #2 i_ref_clk = ~i_ref_clk;
    // Cycle count and an oscillator running as fast as the synchroniser allows.
    always @(posedge i_ref_clk) begin
        cyc <= cyc + 1;
        osc <= ~osc;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic sw_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_ref_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_ref_clk);
        i_wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe.
    task automatic sw_rd(input logic [7:0] a);
        @(posedge i_ref_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_ref_clk);
        i_rd <= 1'b0;
        #1 rd_q = o_rdata;
    endtask
    task automatic dev_rd(input logic sel);
        sw_wr(8'h0C, {23'h0, sel, 8'h00});
        repeat (3) @(posedge i_ref_clk);
        sw_rd(8'h10);
    endtask
    task automatic pulse_rtc();
        @(posedge i_ref_clk);
        rtc <= 1'b1;
        @(posedge i_ref_clk);
        rtc <= 1'b0;
        t0 = cyc;
    endtask
    task automatic wait_rel(input int n);
        while (cyc - t0 < n) @(posedge i_ref_clk);
    endtask
    // Waits for a request and checks that it came close to the due cycle.
    task automatic wait_req(input logic rst, input int due);
        while (cyc - t0 < due + 8) begin
            @(posedge i_ref_clk);
            #1;
            if ((rst ? link_if.rst_req : link_if.nmi_req) === 1'b1) break;
        end
        chk(32'(cyc - t0 > due - 8 && cyc - t0 < due + 8), 32'h1);
        if (cyc - t0 >= due + 8) finish_test();
    endtask
    task automatic finish_test();
        if (failures == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Reset values of both ends and an unmapped address.
    task automatic reset_values();
        dev_rd(1'b0); chk(rd_q, 32'h0A);
        dev_rd(1'b1); chk(rd_q, 32'h00);
        sw_rd(8'h14); chk(rd_q, 32'h00);
        sw_rd(8'h00); chk(rd_q, 32'h00);
    endtask
    // Overflow in NMI mode, then flag, interrupt and clearing.
    task automatic nmi_overflow();
        sw_wr(8'h04, 32'h1);
        pulse_rtc();
        sw_wr(8'h08, 32'h1C);
        dev_rd(1'b0); chk(rd_q, 32'h0C);
        wait_req(1'b0, 262148);
        repeat (3) @(posedge i_ref_clk);
        #1 chk(o_irq, 32'h1);
        sw_rd(8'h00); chk(rd_q, 32'h1);
        dev_rd(1'b1); chk(rd_q, 32'h01);
        sw_wr(8'h00, 32'h1);
        repeat (2) @(posedge i_ref_clk);
        #1 chk(o_irq, 32'h0);
        sw_wr(8'h08, 32'h1C);
        dev_rd(1'b1); chk(rd_q, 32'h00);
    endtask
    // Reset mode; ten ticks lost to sleep and ten to a stop key.
    task automatic reset_overflow();
        sw_wr(8'h08, 32'h102);
        pulse_rtc();
        sw_wr(8'h08, 32'h1C);
        wait_rel(1100);
        sw_wr(8'h08, 32'h1C);
        sleep <= 1'b1;
        wait_rel(3660);
        sleep <= 1'b0;
        wait_rel(5000);
        sw_wr(8'h08, 32'h0A);
        wait_rel(7560);
        sw_wr(8'h08, 32'h0C);
        wait_req(1'b1, 268292);
        @(posedge i_ref_clk);
        #1 chk(o_cpu_reset, 32'h1);
        sw_rd(8'h00); chk(rd_q, 32'h2);
        chk(o_irq, 32'h0);
        dev_rd(1'b1); chk(rd_q, 32'h03);
    endtask

    // Main sequence.
    initial begin
        repeat (6) @(posedge i_ref_clk);
        i_reset_n <= 1'b1;
        reset_values();
        nmi_overflow();
        reset_overflow();
        finish_test();
    end
endmodule
